// >>> rtl/asle_engine.sv
// security lock engine with AXI4-Lite task-file style register slave
// Function
// RL1: erase-unit takes one sector; wrong password aborts the command.
// RL2: erase-unit aborts unless erase-prepare completed directly before it.
// RL3: freeze-lock sets frozen; frozen rejects set, unlock, disable, erase.
// RL4: frozen clears only on power-on or hardware reset.
// RL5: freeze-lock while frozen completes normally and stays frozen.
// RL6: completed freeze-lock loads zero into sector count.
// RL7: without security support, freeze-lock code runs wear-level instead.
// RL8: set-password takes a sector; word0 bit0 user/master, words 1-16 password.
// RL9: control word bit 8 picks level, high or maximum; rest reserved.
// RL10: user password at high: store, arm lock; user or master unlocks.
// RL11: user password at maximum: store, arm lock; master cannot unlock.
// RL12: master set-password stores master; lock enable and level unchanged.
// RL13: unlock master at high level compares against stored master.
// RL14: unlock master at maximum level is rejected.
// RL15: unlock user compares against stored user password.
// RL16: unlock mismatch while locked aborts and decrements counter from five.
// RL17: counter at zero aborts unlock and erase-unit until reset.
// RL18: unlock while already unlocked leaves the counter alone.
// RL19: erase-prepare is recognised by its own command code.
// RL20: erase and unlock sector word0 bit0 picks user or master.
// RL21: rejects set abort and error bits, leaving security state untouched.
// RL22: any reset restores counter and clears erase-prepare pending.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module asle_engine import asle_pkg::*; #(
    parameter bit SEC_SUPPORTED = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wear_level_start,
    output logic erase_start
);
    // bus slave state
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt, araddr_r, araddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, ar_have_r, ar_have_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_en, cmd_wr, data_wr, scnt_wr;

    // engine state
    asle_state_t state_r, state_nxt;
    logic [7:0] cmd_r, cmd_nxt, status_r, status_nxt, error_r, error_nxt;
    logic [7:0] scnt_r, scnt_nxt;
    logic frozen_r, frozen_nxt, locked_r, locked_nxt;
    logic lock_en_r, lock_en_nxt, level_r, level_nxt, prep_r, prep_nxt;
    logic [2:0] tries_r, tries_nxt;
    logic [255:0] user_pw_r, user_pw_nxt, master_pw_r, master_pw_nxt;
    logic wear_r, wear_nxt, erase_r, erase_nxt;
    logic rx_start;
    logic [15:0] ctrl_w;
    logic [255:0] pw_w;
    logic done_w;
    logic ident, match;
    logic [31:0] sec_word;

    assign wr_en = aw_have_r && w_have_r && !bvalid_r;
    assign cmd_wr = wr_en && awaddr_r == ADR_CMD && wstrb_r[0]
        && state_r == ASLE_IDLE;
    assign data_wr = wr_en && awaddr_r == ADR_DATA && wstrb_r[1:0] == 2'h3
        && state_r == ASLE_XFER;
    assign scnt_wr = wr_en && awaddr_r == ADR_SCNT && wstrb_r[0];

    // RL8: sector capture
    asle_sector_rx #(
        .WORDS(SECTOR_WORDS),
        .PWW(PW_WORDS)
    ) u_rx (
        .clk(clk),
        .rst(rst),
        .start(rx_start),
        .wr_valid(data_wr),
        .wr_data(wdata_r[15:0]),
        .ctrl(ctrl_w),
        .pw(pw_w),
        .done(done_w)
    );

    // RL20: identifier picks the compare target
    assign ident = ctrl_w[CTRL_IDENT];
    assign match = ident ? (pw_w == master_pw_r) : (pw_w == user_pw_r);

    always_comb begin
        sec_word = 32'h0000_0000;
        sec_word[SF_FROZEN] = frozen_r;
        sec_word[SF_LOCKED] = locked_r;
        sec_word[SF_LOCKEN] = lock_en_r;
        sec_word[SF_LEVEL] = level_r;
        sec_word[SF_PREP] = prep_r;
        sec_word[SF_TRIES +: 3] = tries_r;
    end

    // AXI4-Lite slave: address and data taken in either order
    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        ar_have_nxt = ar_have_r;
        araddr_nxt = araddr_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && !aw_have_r) begin
            aw_have_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_r) begin
            w_have_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (wr_en) begin
            bvalid_nxt = 1'b1;
            if (awaddr_r == ADR_CMD || awaddr_r == ADR_DATA
                || awaddr_r == ADR_STAT || awaddr_r == ADR_ERR
                || awaddr_r == ADR_SCNT || awaddr_r == ADR_SEC) begin
                bresp_nxt = RESP_OKAY;
            end else begin
                bresp_nxt = RESP_DECERR;
            end
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
        end
        if (s_axi_arvalid && !ar_have_r && !rvalid_r) begin
            ar_have_nxt = 1'b1;
            araddr_nxt = s_axi_araddr;
        end
        if (ar_have_r && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            if (araddr_r == ADR_CMD) begin
                rdata_nxt = {24'h000000, cmd_r};
            end else if (araddr_r == ADR_DATA) begin
                rdata_nxt = 32'h0000_0000;
            end else if (araddr_r == ADR_STAT) begin
                rdata_nxt = {24'h000000, status_r};
            end else if (araddr_r == ADR_ERR) begin
                rdata_nxt = {24'h000000, error_r};
            end else if (araddr_r == ADR_SCNT) begin
                rdata_nxt = {24'h000000, scnt_r};
            end else if (araddr_r == ADR_SEC) begin
                rdata_nxt = sec_word;
            end else begin
                rdata_nxt = 32'h0000_0000;
                rresp_nxt = RESP_DECERR;
            end
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
            ar_have_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            ar_have_r <= 1'b0;
            araddr_r <= '0;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            ar_have_r <= ar_have_nxt;
            araddr_r <= araddr_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // command engine
    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        status_nxt = status_r;
        error_nxt = error_r;
        scnt_nxt = scnt_r;
        frozen_nxt = frozen_r;
        locked_nxt = locked_r;
        lock_en_nxt = lock_en_r;
        level_nxt = level_r;
        prep_nxt = prep_r;
        tries_nxt = tries_r;
        user_pw_nxt = user_pw_r;
        master_pw_nxt = master_pw_r;
        wear_nxt = 1'b0;
        erase_nxt = 1'b0;
        rx_start = 1'b0;
        if (scnt_wr && state_r == ASLE_IDLE) begin
            scnt_nxt = wdata_r[7:0];
        end
        case (state_r)
            ASLE_IDLE: begin
                if (cmd_wr) begin
                    cmd_nxt = wdata_r[7:0];
                    // RL2: any other command ends the prepare window
                    prep_nxt = 1'b0;
                    status_nxt = STAT_IDLE;
                    error_nxt = ERR_NONE;
                    if (wdata_r[7:0] == CMD_FREEZE && !SEC_SUPPORTED) begin
                        // RL7: wear-level stands in
                        wear_nxt = 1'b1;
                    end else if (!SEC_SUPPORTED) begin
                        // no security set: its codes are not recognised
                        status_nxt = STAT_ABORT;
                        error_nxt = ERR_ABORT;
                    end else if (wdata_r[7:0] == CMD_FREEZE) begin
                        // RL3: enter frozen
                        // RL5: repeat freeze completes
                        frozen_nxt = 1'b1;
                        // RL6: sector count cleared
                        scnt_nxt = SCNT_RST;
                    end else if (wdata_r[7:0] == CMD_ERASE_PREP) begin
                        // RL19: prepare code arms erase
                        prep_nxt = 1'b1;
                    end else if (wdata_r[7:0] == CMD_SET_PW
                        || wdata_r[7:0] == CMD_UNLOCK
                        || wdata_r[7:0] == CMD_ERASE_UNIT
                        || wdata_r[7:0] == CMD_DISABLE_PW) begin
                        // RL3: frozen rejects lock changes
                        // RL17: exhausted counter blocks
                        // RL2: erase needs prepare first
                        // RL21: abort without state change
                        if (frozen_r
                            || (tries_r == 3'h0
                                && (wdata_r[7:0] == CMD_UNLOCK
                                    || wdata_r[7:0] == CMD_ERASE_UNIT))
                            || (wdata_r[7:0] == CMD_ERASE_UNIT
                                && !prep_r)) begin
                            status_nxt = STAT_ABORT;
                            error_nxt = ERR_ABORT;
                        end else begin
                            // RL1: one parameter sector follows
                            state_nxt = ASLE_XFER;
                            status_nxt = STAT_DRQ;
                            rx_start = 1'b1;
                        end
                    end else begin
                        status_nxt = STAT_ABORT;
                        error_nxt = ERR_ABORT;
                    end
                end
            end
            ASLE_XFER: begin
                if (done_w) begin
                    state_nxt = ASLE_EXEC;
                    status_nxt = STAT_BUSY;
                end
            end
            ASLE_EXEC: begin
                state_nxt = ASLE_IDLE;
                status_nxt = STAT_IDLE;
                if (cmd_r == CMD_SET_PW) begin
                    if (ident) begin
                        // RL12: master only, lock and level kept
                        master_pw_nxt = pw_w;
                    end else begin
                        // RL9: level from control bit
                        // RL10: high level arms lock
                        // RL11: maximum level arms lock
                        user_pw_nxt = pw_w;
                        lock_en_nxt = 1'b1;
                        level_nxt = ctrl_w[CTRL_LEVEL];
                    end
                end else if (cmd_r == CMD_UNLOCK) begin
                    if (ident && level_r) begin
                        // RL14: master refused at maximum
                        status_nxt = STAT_ABORT;
                        error_nxt = ERR_ABORT;
                    end else if (match) begin
                        // RL13: master compare at high
                        // RL15: user compare
                        locked_nxt = 1'b0;
                    end else begin
                        status_nxt = STAT_ABORT;
                        error_nxt = ERR_ABORT;
                        // RL16: count down only when locked
                        // RL18: unlocked leaves count
                        if (locked_r) begin
                            tries_nxt = tries_r - 3'h1;
                        end
                    end
                end else if (cmd_r == CMD_ERASE_UNIT) begin
                    // RL1: wrong password aborts
                    if (match) begin
                        erase_nxt = 1'b1;
                        locked_nxt = 1'b0;
                        lock_en_nxt = 1'b0;
                        level_nxt = 1'b0;
                    end else begin
                        status_nxt = STAT_ABORT;
                        error_nxt = ERR_ABORT;
                    end
                end
            end
            default: begin
                state_nxt = ASLE_IDLE;
            end
        endcase
        // RL4: hardware reset unfreezes here; rst also clears frozen
        // RL22: counter and prepare restored
        if (hw_reset) begin
            state_nxt = ASLE_IDLE;
            status_nxt = STAT_IDLE;
            error_nxt = ERR_NONE;
            frozen_nxt = 1'b0;
            prep_nxt = 1'b0;
            tries_nxt = TRIES_INIT;
            // armed lock takes hold at this reset
            locked_nxt = lock_en_r;
            wear_nxt = 1'b0;
            erase_nxt = 1'b0;
        end
    end

    // passwords live in flops here; nonvolatile storage is outside the block
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ASLE_IDLE;
            cmd_r <= 8'h00;
            status_r <= STAT_IDLE;
            error_r <= ERR_NONE;
            scnt_r <= SCNT_RST;
            frozen_r <= 1'b0;
            locked_r <= 1'b0;
            lock_en_r <= 1'b0;
            level_r <= 1'b0;
            prep_r <= 1'b0;
            tries_r <= TRIES_INIT;
            user_pw_r <= '0;
            master_pw_r <= '0;
            wear_r <= 1'b0;
            erase_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            status_r <= status_nxt;
            error_r <= error_nxt;
            scnt_r <= scnt_nxt;
            frozen_r <= frozen_nxt;
            locked_r <= locked_nxt;
            lock_en_r <= lock_en_nxt;
            level_r <= level_nxt;
            prep_r <= prep_nxt;
            tries_r <= tries_nxt;
            user_pw_r <= user_pw_nxt;
            master_pw_r <= master_pw_nxt;
            wear_r <= wear_nxt;
            erase_r <= erase_nxt;
        end
    end

    assign s_axi_awready = !aw_have_r;
    assign s_axi_wready = !w_have_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !ar_have_r && !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign wear_level_start = wear_r;
    assign erase_start = erase_r;
endmodule // asle_engine

// >>> common/asle_pkg.sv
// constants of the security lock engine
package asle_pkg;
    // register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADR_CMD = 8'h00;
    localparam logic [7:0] ADR_DATA = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam logic [7:0] ADR_ERR = 8'h0C;
    localparam logic [7:0] ADR_SCNT = 8'h10;
    localparam logic [7:0] ADR_SEC = 8'h14;
    // command codes
    localparam logic [7:0] CMD_SET_PW = 8'hF1;
    localparam logic [7:0] CMD_UNLOCK = 8'hF2;
    localparam logic [7:0] CMD_ERASE_PREP = 8'hF3;
    localparam logic [7:0] CMD_ERASE_UNIT = 8'hF4;
    localparam logic [7:0] CMD_FREEZE = 8'hF5;
    localparam logic [7:0] CMD_DISABLE_PW = 8'hF6;
    // status and error codes
    localparam logic [7:0] STAT_IDLE = 8'h40;
    localparam logic [7:0] STAT_ABORT = 8'h41;
    localparam logic [7:0] STAT_DRQ = 8'h48;
    localparam logic [7:0] STAT_BUSY = 8'hC0;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    localparam logic [7:0] ERR_NONE = 8'h00;
    // parameter sector layout, in 16-bit words
    localparam int SECTOR_WORDS = 256;
    localparam int PW_FIRST = 1;
    localparam int PW_WORDS = 16;
    localparam int CTRL_IDENT = 0;
    localparam int CTRL_LEVEL = 8;
    // security state word fields
    localparam int SF_FROZEN = 0;
    localparam int SF_LOCKED = 1;
    localparam int SF_LOCKEN = 2;
    localparam int SF_LEVEL = 3;
    localparam int SF_PREP = 4;
    localparam int SF_TRIES = 8;
    // unlock attempts after reset
    localparam logic [2:0] TRIES_INIT = 3'h5;
    localparam logic [7:0] SCNT_RST = 8'h00;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [1:0] {ASLE_IDLE, ASLE_XFER, ASLE_EXEC} asle_state_t;
endpackage

// >>> rtl/asle_sector_rx.sv
// parameter sector receiver
`timescale 1ns/1ps
module asle_sector_rx import asle_pkg::*; #(
    parameter int WORDS = SECTOR_WORDS,
    parameter int PWW = PW_WORDS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic wr_valid,
    input wire logic [15:0] wr_data,
    output logic [15:0] ctrl,
    output logic [16*PWW-1:0] pw,
    output logic done
);
    logic [8:0] idx_r, idx_nxt;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic done_r, done_nxt;
    logic [15:0] pw_r [PWW];
    logic [15:0] pw_nxt [PWW];

    always_comb begin
        idx_nxt = idx_r;
        ctrl_nxt = ctrl_r;
        done_nxt = 1'b0;
        if (start) begin
            idx_nxt = 9'h000;
        end else if (wr_valid) begin
            idx_nxt = idx_r + 9'h001;
            if (idx_r == 9'h000) begin
                ctrl_nxt = wr_data;
            end
            // whole sector must arrive, reserved words are dropped
            if (idx_r == 9'(WORDS - 1)) begin
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_r <= 9'h000;
            ctrl_r <= 16'h0000;
            done_r <= 1'b0;
        end else begin
            idx_r <= idx_nxt;
            ctrl_r <= ctrl_nxt;
            done_r <= done_nxt;
        end
    end

    genvar i;
    generate
        for (i = 0; i < PWW; i++) begin : g_pw
            always_comb begin
                pw_nxt[i] = pw_r[i];
                if (wr_valid && !start && idx_r == 9'(PW_FIRST + i)) begin
                    pw_nxt[i] = wr_data;
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    pw_r[i] <= 16'h0000;
                end else begin
                    pw_r[i] <= pw_nxt[i];
                end
            end
            assign pw[16*i +: 16] = pw_r[i];
        end
    endgenerate

    assign ctrl = ctrl_r;
    assign done = done_r;
endmodule // asle_sector_rx

// >>> tb/asle_engine_properties.sv
// port checks for the lock engine
`timescale 1ns/1ps
module asle_engine_chk #(
    parameter bit SEC_SUPPORTED = 1'b1
) (
    input logic clk,
    input logic rst,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic erase_start,
    input logic wear_level_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_w_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_busy: assert property (p_w_busy) else $error("write ready early");
    property p_ar_busy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("arready early");
    property p_b_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_er_pulse;
        erase_start |=> !erase_start;
    endproperty
    a_er_pulse: assert property (p_er_pulse) else $error("erase pulse long");
    property p_wl_off;
        wear_level_start |-> !SEC_SUPPORTED;
    endproperty
    a_wl_off: assert property (p_wl_off) else $error("wear level pulse");
endmodule // asle_engine_chk
bind asle_engine asle_engine_chk #(.SEC_SUPPORTED(SEC_SUPPORTED)) u_chk (
.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
.erase_start(erase_start), .wear_level_start(wear_level_start));

// >>> tb/asle_host.sv
// host model: register bus master
`timescale 1ns/1ps
module asle_host (
    input logic clk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input logic wready,
    input logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input logic arready,
    input logic [31:0] rdata,
    input logic [1:0] rresp,
    input logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // released lines flip: stale values fail
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        forever begin
            @(posedge clk);
            if (awready) {awvalid, awaddr} <= {1'b0, ~a};
            if (wready) {wvalid, wdata} <= {1'b0, ~d};
            if (bvalid) break;
        end
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        forever begin
            @(posedge clk);
            if (arready) {arvalid, araddr} <= {1'b0, ~a};
            if (rvalid) break;
        end
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
endmodule // asle_host

// >>> tb/tb.sv
// bench for the security lock engine
`timescale 1ns/1ps
module tb import asle_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hw_reset = 1'b0;
    logic [7:0] aw, ar;
    logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr, ers, wls;
    logic [31:0] wd, rd;
    logic [1:0] rs;
    int n_fail = 0, checked = 0, cyc = 0, n_er = 0;
    always #5 clk = ~clk;
    asle_host h(.clk(clk), .awaddr(aw), .awvalid(awv), .awready(awr),
        .wdata(wd), .wvalid(wv), .wready(wr), .bvalid(bv), .bready(br),
        .araddr(ar), .arvalid(arv), .arready(arr), .rdata(rd),
        .rresp(rs), .rvalid(rv), .rready(rr));
    asle_engine DUT(.clk(clk), .rst(rst), .hw_reset(hw_reset),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rs),
        .s_axi_rvalid(rv), .s_axi_rready(rr),
        .wear_level_start(wls), .erase_start(ers));
    task wrap_up;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        h.rd(a, d, r);
        chk(d, exp);
    endtask
    task hwr;
        @(posedge clk);
        hw_reset <= 1'b1;
        @(posedge clk);
        hw_reset <= 1'b0;
    endtask
    // sector only on drq; polling rides out busy
    task run(input logic [7:0] c, input logic [15:0] ctl,
        input logic [15:0] pw, input logic [7:0] st);
        logic [31:0] s;
        logic [1:0] r;
        h.wr(ADR_CMD, {24'h0, c});
        h.rd(ADR_STAT, s, r);
        if (s[7:0] === STAT_DRQ)
            for (int i = 0; i < SECTOR_WORDS; i++)
                h.wr(ADR_DATA, i == 0 ? {16'h0, ctl} :
                     i <= PW_WORDS ? {16'h0, pw + 16'(i)} : 32'h0);
        for (int k = 0; k < 8 && s[7:0] !== st; k++) h.rd(ADR_STAT, s, r);
        chk(s, {24'h0, st});
        if (st === STAT_ABORT) rchk(ADR_ERR, {24'h0, ERR_ABORT});
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ers) n_er <= n_er + 1;
        if (cyc == 60000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] blk [4] = '{CMD_SET_PW, CMD_UNLOCK, CMD_DISABLE_PW,
                                CMD_ERASE_UNIT};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rchk(ADR_SEC, 32'h500);
        h.rd(8'h40, d, r);
        chk(32'(r), 32'(RESP_DECERR));
        $display("test 1 done");
        run(CMD_SET_PW, 16'hFEFE, 16'h1000, STAT_IDLE);
        rchk(ADR_SEC, 32'h504);
        run(CMD_SET_PW, 16'h101, 16'h2000, STAT_IDLE);
        rchk(ADR_SEC, 32'h504);
        hwr();
        rchk(ADR_SEC, 32'h506);
        run(CMD_UNLOCK, 16'h0, 16'h3000, STAT_ABORT);
        rchk(ADR_SEC, 32'h406);
        run(CMD_UNLOCK, 16'h1, 16'h2000, STAT_IDLE);
        run(CMD_UNLOCK, 16'h0, 16'h3000, STAT_ABORT);
        rchk(ADR_SEC, 32'h404);
        $display("test 2 done");
        run(CMD_SET_PW, 16'h100, 16'h1000, STAT_IDLE);
        hwr();
        run(CMD_UNLOCK, 16'h1, 16'h2000, STAT_ABORT);
        rchk(ADR_SEC, 32'h50E);
        repeat (5) run(CMD_UNLOCK, 16'h0, 16'h3000, STAT_ABORT);
        rchk(ADR_SEC, 32'h00E);
        run(CMD_UNLOCK, 16'h0, 16'h1000, STAT_ABORT);
        run(CMD_ERASE_PREP, 16'h0, 16'h0, STAT_IDLE);
        run(CMD_ERASE_UNIT, 16'h0, 16'h1000, STAT_ABORT);
        $display("test 3 done");
        hwr();
        run(CMD_ERASE_UNIT, 16'h0, 16'h1000, STAT_ABORT);
        run(CMD_ERASE_PREP, 16'h0, 16'h0, STAT_IDLE);
        rchk(ADR_SEC, 32'h51E);
        run(CMD_ERASE_UNIT, 16'h0, 16'h3000, STAT_ABORT);
        run(CMD_ERASE_PREP, 16'h0, 16'h0, STAT_IDLE);
        hwr();
        run(CMD_ERASE_UNIT, 16'h0, 16'h1000, STAT_ABORT);
        run(CMD_ERASE_PREP, 16'h0, 16'h0, STAT_IDLE);
        run(CMD_ERASE_UNIT, 16'h0, 16'h1000, STAT_IDLE);
        chk(32'(n_er), 32'h1);
        rchk(ADR_SEC, 32'h500);
        $display("test 4 done");
        h.wr(ADR_SCNT, 32'h12);
        rchk(ADR_SCNT, 32'h12);
        run(CMD_FREEZE, 16'h0, 16'h0, STAT_IDLE);
        rchk(ADR_SCNT, 32'h0);
        run(CMD_FREEZE, 16'h0, 16'h0, STAT_IDLE);
        foreach (blk[i]) run(blk[i], 16'h0, 16'h1000, STAT_ABORT);
        rchk(ADR_SEC, 32'h501);
        hwr();
        rchk(ADR_SEC, 32'h500);
        $display("test 5 done");
        wrap_up();
    end
endmodule // tb
